// File: core/nci_consts.svh
// constants for the nand command interface host controller
`ifndef NCI_CONSTS_SVH
`define NCI_CONSTS_SVH
`define NCI_CMD_READ_SETUP 8'h00
`define NCI_CMD_READ_CONFIRM 8'h30
`define NCI_CMD_COPY_READ_CONFIRM 8'h35
`define NCI_CMD_OUT_COL_SETUP 8'h05
`define NCI_CMD_OUT_COL_CONFIRM 8'he0
`define NCI_CMD_PROG_SETUP 8'h80
`define NCI_CMD_IN_COL_CHANGE 8'h85
`define NCI_CMD_PROG_CONFIRM 8'h10
`define NCI_CMD_ERASE_SETUP 8'h60
`define NCI_CMD_ERASE_CONFIRM 8'hd0
`define NCI_CMD_STATUS 8'h70
`define NCI_CMD_RESET 8'hff
`define NCI_STAT_READY_BIT 6
`define NCI_STAT_FAIL_BIT 0
`define NCI_COL_MAX 12'h83f
`define NCI_ADR_CTRL 4'h0
`define NCI_ADR_COL 4'h1
`define NCI_ADR_ROW 4'h2
`define NCI_ADR_WDATA 4'h3
`define NCI_ADR_RDATA 4'h4
`define NCI_ADR_STATUS 4'h5
`define NCI_OP_READ 3'h1
`define NCI_OP_PROG 3'h2
`define NCI_OP_ERASE 3'h3
`define NCI_OP_STATUS 3'h4
`define NCI_OP_RESET 3'h5
`define NCI_OP_COPY_READ 3'h6
`define NCI_OP_COPY_PROG 3'h7
`define NCI_STROBE_NS 20
`define NCI_CLK_NS 5
`define NCI_STROBE_CYC ((`NCI_STROBE_NS + `NCI_CLK_NS - 1) / `NCI_CLK_NS)
`define NCI_WHR_NS 60
`define NCI_WHR_CYC ((`NCI_WHR_NS + `NCI_CLK_NS - 1) / `NCI_CLK_NS)
`endif

// File: core/nci_pkg.sv
// types shared by the nand command interface host controller
package nci_pkg;
   typedef struct packed {
      logic cmd_latch;
      logic addr_latch;
      logic chip_sel_n;
      logic write_strobe_n;
      logic output_strobe_n;
      logic prog_lock_n;
   } nci_pins_t;
   typedef enum logic [2:0] {
      NCI_CYC_CMD = 3'h1,
      NCI_CYC_ADDR = 3'h2,
      NCI_CYC_DIN = 3'h3,
      NCI_CYC_DOUT = 3'h4
   } nci_cyc_t;
endpackage : nci_pkg

// File: core/nci_strobe.sv
// one bus cycle on the flash pins: a write strobe pulse or a read strobe pulse
`timescale 1ns/100ps
`include "nci_consts.svh"
module nci_strobe #(
   parameter int PULSE_CYC = `NCI_STROBE_CYC
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   input wire nci_pkg::nci_cyc_t kind_in,
   input wire logic [7:0] data_in,
   input wire logic [7:0] io_in,
   output logic busy_out,
   output logic done_out,
   output logic [7:0] rdata_out,
   output logic cle_out,
   output logic ale_out,
   output logic we_n_out,
   output logic re_n_out,
   output logic [7:0] io_out,
   output logic io_oe_out
);
   initial begin
      if (PULSE_CYC < 1 || PULSE_CYC > 255) $error("PULSE_CYC out of range");
   end
   logic [8:0] cnt_r;
   nci_pkg::nci_cyc_t kind_r;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_r <= 9'h000;
         kind_r <= nci_pkg::NCI_CYC_CMD;
         busy_out <= 1'b0;
         done_out <= 1'b0;
         cle_out <= 1'b0;
         ale_out <= 1'b0;
         we_n_out <= 1'b1;
         re_n_out <= 1'b1;
         io_out <= 8'h00;
         io_oe_out <= 1'b0;
         rdata_out <= 8'h00;
      end else begin
         done_out <= 1'b0;
         if (start_in && !busy_out) begin
            busy_out <= 1'b1;
            kind_r <= kind_in;
            cnt_r <= 9'(2 * PULSE_CYC);
            // latch selects set cycle type on the same clock edge that the strobe falls
            cle_out <= (kind_in == nci_pkg::NCI_CYC_CMD);
            ale_out <= (kind_in == nci_pkg::NCI_CYC_ADDR);
            io_out <= data_in;
            io_oe_out <= (kind_in != nci_pkg::NCI_CYC_DOUT);
            if (kind_in == nci_pkg::NCI_CYC_DOUT) re_n_out <= 1'b0;
            else we_n_out <= 1'b0;
         end else if (busy_out) begin
            cnt_r <= cnt_r - 9'h001;
            if (cnt_r == 9'(PULSE_CYC + 1)) begin
               // device latches on this rising write edge
               we_n_out <= 1'b1;
               if (kind_r == nci_pkg::NCI_CYC_DOUT) rdata_out <= io_in;
               re_n_out <= 1'b1;
            end
            if (cnt_r == 9'h001) begin
               busy_out <= 1'b0;
               done_out <= 1'b1;
               cle_out <= 1'b0;
               ale_out <= 1'b0;
               io_oe_out <= 1'b0;
            end
         end
      end
   end
endmodule : nci_strobe

// File: core/nci_host.sv
// wishbone-controlled host sequencer for a byte-wide nand flash
`timescale 1ns/100ps
`include "nci_consts.svh"
module nci_host #(
   parameter int COL_W = 12,
   parameter int ROW_W = 16
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [3:0] wb_adr_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [3:0] wb_sel_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   output logic cmd_latch_out,
   output logic addr_latch_out,
   output logic chip_sel_n_out,
   output logic write_strobe_n_out,
   output logic output_strobe_n_out,
   output logic prog_lock_n_out,
   output logic [7:0] io_out,
   output logic io_oe_out,
   input wire logic [7:0] io_in,
   input wire logic ready_busy_n_in
);
   initial begin
      if (COL_W != 12 || ROW_W != 16) $error("address widths must be 12 and 16");
   end
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_CMD1 = 8'h02,
      ST_ADDR = 8'h04,
      ST_CMD2 = 8'h08,
      ST_WAIT = 8'h10,
      ST_GAP = 8'h20,
      ST_BYTE = 8'h40,
      ST_DONE = 8'h80
   } nci_state_t;
   nci_state_t state_r;
   logic [2:0] op_r;
   logic [1:0] addr_idx_r;
   logic [2:0] addr_last_r;
   logic [COL_W-1:0] col_r;
   logic [ROW_W-1:0] row_r;
   logic [7:0] wdata_r;
   logic [7:0] rdata_r;
   logic rdata_valid_r;
   logic busy_r;
   logic lock_n_r;
   logic col_only_r;
   logic [ROW_W-1:0] prog_row_r;
   logic [2:0] prog_cnt_r;
   logic [7:0] gap_r;
   logic byte_op_r;
   logic byte_rd_r;
   logic sub_start_r;
   nci_pkg::nci_cyc_t sub_kind_r;
   logic [7:0] sub_data_r;
   logic sub_busy;
   logic sub_done;
   logic [7:0] sub_rdata;
   logic sub_cle;
   logic sub_ale;
   logic sub_we_n;
   logic sub_re_n;
   logic [7:0] sub_io;
   logic sub_oe;
   logic wb_req;
   assign wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
   function automatic logic [7:0] first_code(input logic [2:0] op);
      case (op)
         `NCI_OP_READ: first_code = `NCI_CMD_READ_SETUP;
         `NCI_OP_COPY_READ: first_code = `NCI_CMD_READ_SETUP;
         `NCI_OP_PROG: first_code = `NCI_CMD_PROG_SETUP;
         `NCI_OP_COPY_PROG: first_code = `NCI_CMD_IN_COL_CHANGE;
         `NCI_OP_ERASE: first_code = `NCI_CMD_ERASE_SETUP;
         `NCI_OP_STATUS: first_code = `NCI_CMD_STATUS;
         default: first_code = `NCI_CMD_RESET;
      endcase
   endfunction : first_code
   function automatic logic [7:0] second_code(input logic [2:0] op);
      case (op)
         `NCI_OP_READ: second_code = `NCI_CMD_READ_CONFIRM;
         `NCI_OP_COPY_READ: second_code = `NCI_CMD_COPY_READ_CONFIRM;
         `NCI_OP_ERASE: second_code = `NCI_CMD_ERASE_CONFIRM;
         default: second_code = `NCI_CMD_PROG_CONFIRM;
      endcase
   endfunction : second_code
   function automatic logic is_prog_op(input logic [2:0] op);
      is_prog_op = (op == `NCI_OP_PROG || op == `NCI_OP_COPY_PROG);
   endfunction : is_prog_op
   function automatic logic [7:0] addr_byte(input logic [2:0] i, input logic [COL_W-1:0] c,
                                            input logic [ROW_W-1:0] r);
      case (i)
         3'h0: addr_byte = c[7:0];
         3'h1: addr_byte = {4'h0, c[11:8]};
         3'h2: addr_byte = r[7:0];
         default: addr_byte = r[15:8];
      endcase
   endfunction : addr_byte
   // bus slave: ack one cycle after request, registers decoded by if chain
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end else begin
         wb_ack_out <= wb_req;
         if (wb_req && !wb_we_in) begin
            if (wb_adr_in == `NCI_ADR_COL) wb_dat_out <= {20'h00000, col_r};
            else if (wb_adr_in == `NCI_ADR_ROW) wb_dat_out <= {16'h0000, row_r};
            else if (wb_adr_in == `NCI_ADR_RDATA) wb_dat_out <= {24'h000000, rdata_r};
            else if (wb_adr_in == `NCI_ADR_STATUS) begin
               wb_dat_out <= {27'h0000000, lock_n_r, ready_busy_n_in, rdata_valid_r, busy_r};
            end else wb_dat_out <= 32'h0000_0000;
         end
      end
   end
   logic wr_ctrl;
   logic wr_byte;
   assign wr_ctrl = wb_req && wb_we_in && wb_sel_in[0] && wb_adr_in == `NCI_ADR_CTRL;
   assign wr_byte = wb_req && wb_we_in && wb_sel_in[0] && !busy_r &&
                    (wb_adr_in == `NCI_ADR_WDATA || wb_adr_in == `NCI_ADR_RDATA);
   logic cfm_req;
   logic ctrl_go;
   // one confirm carries every main and spare byte written since setup, so a sector goes whole
   assign cfm_req = wb_dat_in[4] && is_prog_op(wb_dat_in[2:0]);
   assign ctrl_go = wr_ctrl && !busy_r && wb_dat_in[2:0] != 3'h0 &&
                    !(cfm_req && row_r == prog_row_r && prog_cnt_r == 3'h4);
   // only the last confirmed row is tracked; rows taken in turn each restart the count
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         prog_row_r <= '0;
         prog_cnt_r <= 3'h0;
      end else if (state_r == ST_IDLE && ctrl_go && cfm_req) begin
         if (row_r != prog_row_r) begin
            prog_row_r <= row_r;
            prog_cnt_r <= 3'h1;
         end else prog_cnt_r <= prog_cnt_r + 3'h1;
      end
   end
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         col_r <= '0;
         row_r <= '0;
         wdata_r <= 8'h00;
         lock_n_r <= 1'b0;
      end else if (wb_req && wb_we_in && !busy_r) begin
         if (wb_adr_in == `NCI_ADR_COL) begin
            // columns past the page hold hidden parity; such a value is dropped
            if (wb_dat_in[COL_W-1:0] <= `NCI_COL_MAX) col_r <= wb_dat_in[COL_W-1:0];
         end else if (wb_adr_in == `NCI_ADR_ROW) row_r <= wb_dat_in[ROW_W-1:0];
         else if (wb_adr_in == `NCI_ADR_WDATA) wdata_r <= wb_dat_in[7:0];
         else if (wb_adr_in == `NCI_ADR_CTRL && wb_sel_in[1]) lock_n_r <= wb_dat_in[8];
      end
   end
   // sequencer
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_r <= ST_IDLE;
         op_r <= 3'h0;
         addr_idx_r <= 2'h0;
         addr_last_r <= 3'h0;
         busy_r <= 1'b0;
         gap_r <= 8'h00;
         byte_op_r <= 1'b0;
         byte_rd_r <= 1'b0;
         sub_start_r <= 1'b0;
         sub_kind_r <= nci_pkg::NCI_CYC_CMD;
         sub_data_r <= 8'h00;
         rdata_r <= 8'h00;
         rdata_valid_r <= 1'b0;
         chip_sel_n_out <= 1'b1;
         col_only_r <= 1'b0;
      end else begin
         sub_start_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (ctrl_go) begin
                  op_r <= wb_dat_in[2:0];
                  col_only_r <= wb_dat_in[3] && !cfm_req &&
                                (wb_dat_in[2:0] == `NCI_OP_READ || is_prog_op(wb_dat_in[2:0]));
                  busy_r <= 1'b1;
                  byte_op_r <= 1'b0;
                  chip_sel_n_out <= 1'b0;
                  // program confirm goes out alone, after the data bytes
                  state_r <= cfm_req ? ST_CMD2 : ST_CMD1;
               end else if (wr_byte) begin
                  // single data byte: write register feeds input, read register drains output
                  busy_r <= 1'b1;
                  byte_op_r <= 1'b1;
                  byte_rd_r <= (wb_adr_in == `NCI_ADR_RDATA);
                  rdata_valid_r <= 1'b0;
                  chip_sel_n_out <= 1'b0;
                  state_r <= ST_BYTE;
               end
            end
            ST_CMD1: begin
               // no new start on the done pulse, or the cycle would repeat
               if (!sub_busy && !sub_start_r && !sub_done) begin
                  sub_kind_r <= nci_pkg::NCI_CYC_CMD;
                  if (!col_only_r) sub_data_r <= first_code(op_r);
                  else if (op_r == `NCI_OP_READ) sub_data_r <= `NCI_CMD_OUT_COL_SETUP;
                  else sub_data_r <= `NCI_CMD_IN_COL_CHANGE;
                  sub_start_r <= 1'b1;
               end
               if (sub_done) begin
                  addr_idx_r <= 2'h0;
                  // a column change carries only the two column bytes
                  if (col_only_r) addr_last_r <= 3'h2;
                  else if (op_r == `NCI_OP_ERASE) addr_last_r <= 3'h3;
                  else addr_last_r <= 3'h4;
                  if (op_r == `NCI_OP_STATUS || op_r == `NCI_OP_RESET) state_r <= ST_WAIT;
                  else state_r <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               if (!sub_busy && !sub_start_r && !sub_done) begin
                  sub_kind_r <= nci_pkg::NCI_CYC_ADDR;
                  // erase sends only the row bytes
                  sub_data_r <= addr_byte((op_r == `NCI_OP_ERASE) ? 3'(addr_idx_r) + 3'h2
                                                               : 3'(addr_idx_r), col_r, row_r);
                  sub_start_r <= 1'b1;
               end
               if (sub_done) begin
                  addr_idx_r <= addr_idx_r + 2'h1;
                  if (3'(addr_idx_r) + 3'h1 + ((op_r == `NCI_OP_ERASE) ? 3'h1 : 3'h0)
                      == addr_last_r) begin
                     // program ops stop here; data bytes follow via the write register
                     if (is_prog_op(op_r)) state_r <= ST_DONE;
                     else state_r <= ST_CMD2;
                  end
               end
            end
            ST_CMD2: begin
               if (!sub_busy && !sub_start_r && !sub_done) begin
                  sub_kind_r <= nci_pkg::NCI_CYC_CMD;
                  sub_data_r <= col_only_r ? `NCI_CMD_OUT_COL_CONFIRM : second_code(op_r);
                  sub_start_r <= 1'b1;
               end
               if (sub_done) state_r <= ST_WAIT;
            end
            ST_WAIT: begin
               // strobes stay high while device is busy; wait out the busy onset
               if (gap_r != 8'(`NCI_WHR_CYC)) gap_r <= gap_r + 8'h01;
               else if (ready_busy_n_in) begin
                  gap_r <= 8'h00;
                  state_r <= ST_DONE;
               end
            end
            ST_BYTE: begin
               if (!sub_busy && !sub_start_r && !sub_done) begin
                  sub_kind_r <= byte_rd_r ? nci_pkg::NCI_CYC_DOUT : nci_pkg::NCI_CYC_DIN;
                  sub_data_r <= wdata_r;
                  sub_start_r <= 1'b1;
               end
               if (sub_done) begin
                  if (byte_rd_r) begin
                     rdata_r <= sub_rdata;
                     rdata_valid_r <= 1'b1;
                  end
                  state_r <= ST_DONE;
               end
            end
            ST_DONE: begin
               busy_r <= 1'b0;
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
   nci_strobe u_strobe (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .start_in(sub_start_r),
      .kind_in(sub_kind_r),
      .data_in(sub_data_r),
      .io_in(io_in),
      .busy_out(sub_busy),
      .done_out(sub_done),
      .rdata_out(sub_rdata),
      .cle_out(sub_cle),
      .ale_out(sub_ale),
      .we_n_out(sub_we_n),
      .re_n_out(sub_re_n),
      .io_out(sub_io),
      .io_oe_out(sub_oe)
   );
   // pin outputs come straight from strobe-engine flip-flops, lock pin registered here
   always_comb begin
      cmd_latch_out = sub_cle;
      addr_latch_out = sub_ale;
      write_strobe_n_out = sub_we_n;
      output_strobe_n_out = sub_re_n;
      io_out = sub_io;
      io_oe_out = sub_oe;
      prog_lock_n_out = lock_n_r;
   end
endmodule : nci_host

// File: test/nci_flash_model.sv
// behavioural flash device as seen from the host pins
`timescale 1ns/100ps
module nci_flash_model #(
   parameter int BUSY_NS = 300
) (
   input wire nci_pkg::nci_pins_t pins_in,
   input wire logic [7:0] io_in,
   output logic [7:0] io_out,
   output logic ready_busy_n_out
);
   // only 256 buffer bytes: column bits above 7 alias
   logic [7:0] pb [256];
   logic [7:0] a [4];
   logic [7:0] cmd = 8'h00;
   logic [11:0] col = 12'h000;
   logic busy = 1'b0;
   logic stat = 1'b0;
   logic [7:0] q = 8'h00;
   int na = 0;
   int ners = 0;
   int nbz = 0;
   int nprg = 0;
   logic [1:0] sec = 2'h0;
   assign ready_busy_n_out = !busy;
   // released bus shows the inverse so a stale byte never passes
   assign io_out = (!pins_in.chip_sel_n && !pins_in.output_strobe_n) ? q : ~q;
   always @(posedge busy) begin
      nbz++;
      #BUSY_NS busy = 1'b0;
   end
   always @(posedge pins_in.write_strobe_n) begin
      if (!pins_in.chip_sel_n && pins_in.cmd_latch) begin
         if (!busy || io_in == 8'h70 || io_in == 8'hff) begin
            if (io_in inside {8'h00, 8'h05, 8'h10, 8'h30, 8'h35, 8'h60, 8'h70, 8'h80,
                  8'h85, 8'hd0, 8'he0, 8'hff}) begin
               cmd = io_in;
               stat = (io_in == 8'h70);
            end
            case (io_in)
               8'h00, 8'h05, 8'h80, 8'h85: na = 0;
               8'h60: na = 2;
               8'he0: col = {a[1][3:0], a[0]};
               8'h30, 8'h35: begin
                  col = {a[1][3:0], a[0]};
                  for (int i = 0; i < 256; i++) pb[i] = i[7:0] ^ 8'ha5;
                  busy = 1'b1;
               end
               8'h10, 8'hd0: if (pins_in.prog_lock_n) begin
                  ners = ners + int'(io_in == 8'hd0);
                  nprg = nprg + int'(io_in == 8'h10);
                  busy = 1'b1;
               end
               8'hff: busy = 1'b1;
               default: ;
            endcase
         end
      end else if (!pins_in.chip_sel_n && pins_in.addr_latch) begin
         if (na < 4) a[na] = io_in;
         na++;
         if (na == 2) col = {a[1][3:0], a[0]};
      end else if (!pins_in.chip_sel_n) begin
         pb[col[7:0]] = io_in;
         sec = (col < 12'h800) ? col[10:9] : col[5:4];
         col++;
      end
   end
   // stored bytes never corrupt, so the fail bit stays clear
   always @(negedge pins_in.output_strobe_n) begin
      if (!pins_in.chip_sel_n) begin
         q = stat ? {pins_in.prog_lock_n, 2'b11, 5'h00} : pb[col[7:0]];
         if (!stat) col++;
      end
   end
endmodule : nci_flash_model

// File: test/nci_host_sva.sv
// pin timing checks for the nand host sequencer
`timescale 1ns/100ps
module nci_host_sva (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic cmd_latch_out,
   input wire logic addr_latch_out,
   input wire logic chip_sel_n_out,
   input wire logic write_strobe_n_out,
   input wire logic output_strobe_n_out,
   input wire logic [7:0] io_out,
   input wire logic io_oe_out,
   input wire logic ready_busy_n_in
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   property p_one_latch;
      !write_strobe_n_out |-> !(cmd_latch_out && addr_latch_out);
   endproperty
   a_one_latch: assert property (p_one_latch) else $error("both latches high");
   property p_rd_cyc;
      !output_strobe_n_out |-> !cmd_latch_out && !addr_latch_out && !io_oe_out;
   endproperty
   a_rd_cyc: assert property (p_rd_cyc) else $error("bad read cycle");
   property p_sel;
      !write_strobe_n_out || !output_strobe_n_out |-> !chip_sel_n_out;
   endproperty
   a_sel: assert property (p_sel) else $error("strobe while deselected");
   property p_busy_q;
      !ready_busy_n_in && !chip_sel_n_out |-> write_strobe_n_out && output_strobe_n_out;
   endproperty
   a_busy_q: assert property (p_busy_q) else $error("strobe while busy");
   property p_wr_drv;
      !write_strobe_n_out |-> io_oe_out;
   endproperty
   a_wr_drv: assert property (p_wr_drv) else $error("bus not driven");
   property p_pulse;
      $fell(write_strobe_n_out) |-> !write_strobe_n_out [*4] ##1 write_strobe_n_out;
   endproperty
   a_pulse: assert property (p_pulse) else $error("write pulse width");
   property p_hold;
      $fell(write_strobe_n_out) |=> ($stable(cmd_latch_out) && $stable(io_out)) [*4];
   endproperty
   a_hold: assert property (p_hold) else $error("latch or data moved");
   property p_rd_pulse;
      $fell(output_strobe_n_out) |-> !output_strobe_n_out [*4] ##1 output_strobe_n_out;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse width");
   c_rd: cover property ($fell(output_strobe_n_out));
   c_cmd: cover property ($fell(write_strobe_n_out) && cmd_latch_out);
   c_busy: cover property ($fell(ready_busy_n_in));
endmodule : nci_host_sva

// File: test/nci_host_tb.sv
// self-checking bench for the nand host sequencer
`timescale 1ns/100ps
`include "nci_consts.svh"
module nci_host_tb;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic wb_cyc_in = 1'b0;
   logic wb_stb_in = 1'b0;
   logic wb_we_in = 1'b0;
   logic [3:0] wb_adr_in = 4'h0;
   logic [31:0] wb_dat_in = 32'h0;
   logic [3:0] wb_sel_in = 4'h3;
   logic [31:0] wb_dat_out;
   logic wb_ack_out, cmd_latch_out, addr_latch_out, chip_sel_n_out, io_oe_out;
   logic write_strobe_n_out, output_strobe_n_out, prog_lock_n_out, ready_busy_n_in;
   logic [7:0] io_out, io_in, dq;
   logic lk = 1'b0;
   int err_total = 0;
   int tests_run = 0;
   int cycles = 0;
   nci_pkg::nci_pins_t pins;
   always #2.5 clk_in = ~clk_in;
   assign pins = {cmd_latch_out, addr_latch_out, chip_sel_n_out, write_strobe_n_out,
      output_strobe_n_out, prog_lock_n_out};
   assign io_in = io_oe_out ? io_out : dq;
   nci_host uut (.clk_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
      .wb_dat_in, .wb_sel_in, .wb_dat_out, .wb_ack_out, .cmd_latch_out, .addr_latch_out,
      .chip_sel_n_out, .write_strobe_n_out, .output_strobe_n_out, .prog_lock_n_out,
      .io_out, .io_oe_out, .io_in, .ready_busy_n_in);
   nci_flash_model dev (.pins_in(pins), .io_in(io_in), .io_out(dq),
      .ready_busy_n_out(ready_busy_n_in));
   task automatic close_out;
      $display("mismatches %0d comparisons %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= w;
      wb_adr_in <= a;
      wb_dat_in <= d;
      do @(posedge clk_in); while (wb_ack_out !== 1'b1);
      q = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
   endtask : wb
   task automatic idle;
      logic [31:0] s;
      s = 32'h1;
      for (int i = 0; i < 400 && s[0] !== 1'b0; i++) wb(1'b0, `NCI_ADR_STATUS, 32'h0, s);
      chk({31'h0, s[0]}, 32'h0);
   endtask : idle
   task automatic op(input logic [2:0] o);
      opx(o, 5'h00);
   endtask : op
   task automatic opx(input logic [2:0] o, input logic [4:0] m);
      logic [31:0] q;
      wb(1'b1, `NCI_ADR_CTRL, {23'h0, lk, m, o}, q);
      idle;
   endtask : opx
   task automatic rdbyte(output logic [31:0] q);
      wb(1'b1, `NCI_ADR_RDATA, 32'h0, q);
      idle;
      wb(1'b0, `NCI_ADR_RDATA, 32'h0, q);
      q = {24'h0, q[7:0]};
   endtask : rdbyte
   task automatic t_reset;
      chk({24'h0, write_strobe_n_out, output_strobe_n_out, chip_sel_n_out, prog_lock_n_out,
         wb_ack_out, io_oe_out, cmd_latch_out, addr_latch_out}, 32'he0);
   endtask : t_reset
   task automatic t_read;
      logic [31:0] q;
      wb(1'b1, `NCI_ADR_COL, 32'h7fe, q);
      wb(1'b1, `NCI_ADR_ROW, 32'h1234, q);
      op(`NCI_OP_READ);
      chk({dev.a[3], dev.a[2], dev.a[1], dev.a[0]}, 32'h1234_07fe);
      chk(dev.nbz, 32'h1);
      for (int i = 0; i < 2; i++) begin
         rdbyte(q);
         chk(q, {24'h0, 8'hfe + i[7:0] ^ 8'ha5});
      end
      wb(1'b1, `NCI_ADR_COL, 32'h005, q);
      opx(`NCI_OP_READ, 5'h01);
      rdbyte(q);
      chk(q, 32'ha0);
   endtask : t_read
   task automatic t_lock;
      logic [31:0] q;
      wb(1'b1, `NCI_ADR_ROW, 32'h0040, q);
      op(`NCI_OP_ERASE);
      chk(dev.ners, 32'h0);
      lk = 1'b1;
      op(`NCI_OP_ERASE);
      chk(dev.ners, 32'h1);
      chk({15'h0, prog_lock_n_out, dev.a[3], dev.a[2]}, 32'h1_0040);
      op(`NCI_OP_STATUS);
      for (int i = 0; i < 2; i++) begin
         rdbyte(q);
         chk(q, 32'he0);
      end
   endtask : t_lock
   task automatic t_ops;
      logic [2:0] ops [6] = '{`NCI_OP_READ, `NCI_OP_COPY_READ, `NCI_OP_PROG,
         `NCI_OP_COPY_PROG, `NCI_OP_STATUS, `NCI_OP_RESET};
      logic [7:0] cds [6] = '{8'h30, 8'h35, 8'h80, 8'h85, 8'h70, 8'hff};
      for (int i = 0; i < 6; i++) begin
         op(ops[i]);
         chk({24'h0, dev.cmd}, {24'h0, cds[i]});
      end
   endtask : t_ops
   task automatic t_prog;
      logic [31:0] q;
      wb(1'b1, `NCI_ADR_COL, 32'h010, q);
      op(`NCI_OP_PROG);
      wb(1'b1, `NCI_ADR_WDATA, 32'h3c, q);
      idle;
      wb(1'b1, `NCI_ADR_WDATA, 32'hc3, q);
      idle;
      chk({16'h0, dev.pb[8'h11], dev.pb[8'h10]}, 32'hc33c);
      wb(1'b1, `NCI_ADR_COL, 32'h810, q);
      opx(`NCI_OP_PROG, 5'h01);
      wb(1'b1, `NCI_ADR_WDATA, 32'h5a, q);
      idle;
      chk({22'h0, dev.sec, dev.pb[8'h10]}, 32'h15a);
      wb(1'b1, `NCI_ADR_COL, 32'h020, q);
      op(`NCI_OP_COPY_PROG);
      wb(1'b1, `NCI_ADR_WDATA, 32'h77, q);
      idle;
      chk({24'h0, dev.pb[8'h20]}, 32'h77);
      for (int i = 0; i < 5; i++) opx(`NCI_OP_PROG, 5'h02);
      chk(dev.nprg, 32'h4);
      chk({24'h0, dev.cmd}, 32'h10);
   endtask : t_prog
   task automatic t_bus;
      logic [31:0] q;
      wb(1'b0, 4'he, 32'h0, q);
      wb(1'b1, `NCI_ADR_CTRL, {23'h0, lk, 5'h0, `NCI_OP_READ}, q);
      // column write lands while busy and must be dropped
      wb(1'b1, `NCI_ADR_COL, 32'h0ab, q);
      idle;
      op(`NCI_OP_READ);
      chk({24'h0, dev.a[0]}, 32'h20);
      wb(1'b1, `NCI_ADR_COL, 32'h850, q);
      wb(1'b0, `NCI_ADR_COL, 32'h0, q);
      chk(q, 32'h020);
      wb(1'b0, `NCI_ADR_STATUS, 32'h0, q);
      chk(q, 32'h00c);
   endtask : t_bus
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 40000) begin
         err_total++;
         close_out;
      end
   end
   initial begin
      repeat (8) @(posedge clk_in);
      t_reset;
      rst_in <= 1'b0;
      t_read;
      t_lock;
      t_ops;
      t_prog;
      t_bus;
      close_out;
   end
endmodule : nci_host_tb
bind nci_host nci_host_sva chk (.clk_in, .rst_in, .cmd_latch_out, .addr_latch_out,
   .chip_sel_n_out, .write_strobe_n_out, .output_strobe_n_out, .io_out, .io_oe_out,
   .ready_busy_n_in);
